/* design/dsip_params.svh */
// Purpose: Constants for the serial DAC input port and its host.
// Assumes: 200 MHz system clock on both ends.
// Notes:   Guarded; definitions only.
`ifndef DSIP_PARAMS_SVH
`define DSIP_PARAMS_SVH

`define DSIP_SHIFT_W      16
`define DSIP_CODE_W       10
`define DSIP_CODE_MSB     11
`define DSIP_CODE_LSB     2
`define DSIP_DAC_RESET    10'h000
`define DSIP_CLK_NS       5
`define DSIP_SCLK_MIN_NS  25
// Half period cycles, rounded up from the least high/low width
`define DSIP_HALF_CYC     ((`DSIP_SCLK_MIN_NS + `DSIP_CLK_NS - 1) / `DSIP_CLK_NS)
`define DSIP_CS_HIGH_NS   20
`define DSIP_CS_HIGH_CYC  ((`DSIP_CS_HIGH_NS + `DSIP_CLK_NS - 1) / `DSIP_CLK_NS)
`define DSIP_FRAME_BITS   16

`endif

/* design/dsip_pkg.sv */
// Purpose: Types for the serial DAC port; code and word types shared by both ends, state type host only.
// Assumes: Constants come from dsip_params.svh.
// Notes:   No imports; use dsip_pkg::name.
`include "dsip_params.svh"
package dsip_pkg;
	typedef logic [`DSIP_CODE_W-1:0]  dsip_code_t;
	typedef logic [`DSIP_SHIFT_W-1:0] dsip_word_t;
	typedef enum logic [2:0] {DSIP_IDLE, DSIP_SETUP, DSIP_HIGH, DSIP_LOW, DSIP_TAIL, DSIP_GAP} dsip_hstate_t;
endpackage : dsip_pkg

/* design/dsip_link_if.sv */
// Purpose: Three-wire link plus daisy output between host and DAC port.
// Assumes: Host drives clock, select and data; device drives data out.
// Notes:   Plain wires, no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface dsip_link_if;
	logic sclk;   // Serial clock
	logic cs_n;   // Chip select, active low
	logic din;    // Data into device
	logic dout;   // Daisy data out of device
	modport host   (output sclk, output cs_n, output din, input dout);
	modport device (input sclk, input cs_n, input din, output dout);
endinterface : dsip_link_if
`default_nettype wire

/* design/dsip_buf2.sv */
// Purpose: Two-entry valid/ready buffer.
// Assumes: Same clock on both sides.
// Notes:   Fill side stalls when both entries held.
`timescale 1ns/1ps
`default_nettype none
module dsip_buf2 #(
	parameter int W = 16          // Word width
) (
	input  wire logic         i_clk,     // System clock
	input  wire logic         i_resetn,  // Async reset, active low
	input  wire logic         i_valid,   // Fill side valid
	output logic              o_ready,   // Fill side ready
	input  wire logic [W-1:0] i_data,    // Fill side word
	output logic              o_valid,   // Drain side valid
	input  wire logic         i_ready,   // Drain side ready
	output logic [W-1:0]      o_data     // Drain side word
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic              rd;
		logic              wr;
		logic [1:0]        cnt;
		logic              rdy;
	} dsip_buf_st_t;
	dsip_buf_st_t s_q, s_d;

	// Pointer and count update
	always_comb begin
		logic push;
		logic pop;
		push = 1'b0;
		pop  = 1'b0;
		s_d  = s_q;
		push = i_valid && (s_q.cnt != 2'd2);
		pop  = i_ready && (s_q.cnt != 2'd0);
		if (push) begin
			s_d.mem[s_q.wr] = i_data;
			s_d.wr          = ~s_q.wr;
		end
		if (pop)
			s_d.rd = ~s_q.rd;
		s_d.cnt = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
		s_d.rdy = (s_d.cnt != 2'd2);   // Registered room flag
	end

	// State register
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_q     <= '0;
			s_q.rdy <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_ready = s_q.rdy;
	assign o_valid = (s_q.cnt != 2'd0);
	assign o_data  = s_q.mem[s_q.rd];
endmodule : dsip_buf2
`default_nettype wire

/* design/dsip_device.sv */
// Purpose: Serial input port of a 10-bit voltage DAC.
// Assumes: Link pins are asynchronous; sampled through two flops.
// Notes:   Analog path reduced to the held code output.
`timescale 1ns/1ps
`default_nettype none
`include "dsip_params.svh"
module dsip_device (
	input  wire logic          i_clk,      // System clock
	input  wire logic          i_resetn,   // Async reset, active low
	dsip_link_if.device        link,       // Serial link
	output var dsip_pkg::dsip_code_t o_code,   // Code driving converter
	output logic               o_update,   // Pulse on new code load
	output logic               o_dout_oe   // Daisy output enable
);
	typedef struct packed {
		logic [1:0]          sclk_s;
		logic [1:0]          cs_s;
		logic [1:0]          din_s;
		logic                sclk_p;
		logic                cs_p;
		dsip_pkg::dsip_word_t sr;
		dsip_pkg::dsip_code_t code;
		logic                upd;
		logic                dout;
		logic                oe;
	} dsip_dev_st_t;
	dsip_dev_st_t s_q, s_d;

	// Edge of a synchronised pin against its previous sample
	function automatic logic dsip_edge(input logic now, input logic prev, input logic to_high);
		return to_high ? (now && !prev) : (!now && prev);
	endfunction : dsip_edge

	// Edge finding and shifting
	always_comb begin
		logic rise;
		logic fall;
		logic cs_rise;
		rise    = 1'b0;
		fall    = 1'b0;
		cs_rise = 1'b0;
		s_d        = s_q;
		s_d.sclk_s = {s_q.sclk_s[0], link.sclk};
		s_d.cs_s   = {s_q.cs_s[0], link.cs_n};
		s_d.din_s  = {s_q.din_s[0], link.din};
		s_d.sclk_p = s_q.sclk_s[1];
		s_d.cs_p   = s_q.cs_s[1];
		s_d.upd    = 1'b0;
		s_d.oe     = 1'b1;   // Totem pole, driven once out of reset
		rise    = dsip_edge(s_q.sclk_s[1], s_q.sclk_p, 1'b1);
		fall    = dsip_edge(s_q.sclk_s[1], s_q.sclk_p, 1'b0);
		cs_rise = dsip_edge(s_q.cs_s[1], s_q.cs_p, 1'b1);
		// Shift only while selected
		if (!s_q.cs_s[1] && rise)
			s_d.sr = {s_q.sr[`DSIP_SHIFT_W-2:0], s_q.din_s[1]};
		// Daisy bit leaves on the fall after 16 rises
		if (!s_q.cs_s[1] && fall)
			s_d.dout = s_q.sr[`DSIP_SHIFT_W-1];
		// Straight binary code load on select rise
		if (cs_rise) begin
			s_d.code = s_q.sr[`DSIP_CODE_MSB:`DSIP_CODE_LSB];
			s_d.upd  = 1'b1;
		end
	end

	// State register, code cleared at power-up
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_q        <= '0;
			s_q.cs_s   <= 2'b11;
			s_q.cs_p   <= 1'b1;
			s_q.code   <= `DSIP_DAC_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_code    = s_q.code;
	assign o_update  = s_q.upd;
	assign link.dout = s_q.dout;   // Held while deselected
	assign o_dout_oe = s_q.oe;     // Totem pole, driven from the first cycle after reset
endmodule : dsip_device
`default_nettype wire

/* design/dsip_host.sv */
// Purpose: Host serial controller writing 16-bit frames to the DAC port.
// Assumes: Words arrive on a valid/ready user port.
// Notes:   Sends 16 rises plus a trailing fall for chaining.
`timescale 1ns/1ps
`default_nettype none
`include "dsip_params.svh"
module dsip_host (
	input  wire logic          i_clk,      // System clock
	input  wire logic          i_resetn,   // Async reset, active low
	input  wire logic          i_valid,    // Word offered
	output logic               o_ready,    // Buffer accepts word
	input  wire dsip_pkg::dsip_code_t i_code, // Code to send
	dsip_link_if.host          link,       // Serial link
	output logic               o_busy      // Frame in flight
);
	localparam int HALF = `DSIP_HALF_CYC;
	localparam int GAP  = `DSIP_CS_HIGH_CYC;

	logic                 b_valid;
	logic                 b_ready;
	dsip_pkg::dsip_word_t b_data;

	// Frame: four dummies, code, two zero sub-LSBs
	dsip_buf2 #(.W(`DSIP_SHIFT_W)) u_buf (
		.i_clk   (i_clk),
		.i_resetn(i_resetn),
		.i_valid (i_valid),
		.o_ready (o_ready),
		.i_data  ({4'h0, i_code, 2'h0}),
		.o_valid (b_valid),
		.i_ready (b_ready),
		.o_data  (b_data)
	);

	typedef struct packed {
		dsip_pkg::dsip_hstate_t st;
		dsip_pkg::dsip_word_t   sr;
		logic [4:0]             bits;
		logic [7:0]             tmr;
		logic                   sclk;
		logic                   cs_n;
		logic                   din;
		logic                   busy;
	} dsip_host_st_t;
	dsip_host_st_t s_q, s_d;

	// Frame sequencer
	always_comb begin
		s_d     = s_q;
		b_ready = 1'b0;
		if (s_q.tmr != 8'h00)
			s_d.tmr = s_q.tmr - 8'h01;
		unique case (s_q.st)
			dsip_pkg::DSIP_IDLE: begin
				if (b_valid) begin
					b_ready  = 1'b1;
					s_d.sr   = b_data;
					s_d.cs_n = 1'b0;   // Clock is low here
					s_d.din  = b_data[`DSIP_SHIFT_W-1];
					s_d.bits = 5'd0;
					s_d.tmr  = 8'(HALF);
					s_d.st   = dsip_pkg::DSIP_SETUP;
				end
			end
			dsip_pkg::DSIP_SETUP, dsip_pkg::DSIP_LOW: begin
				if (s_q.tmr == 8'h00) begin
					s_d.sclk = 1'b1;   // Half periods of six cycles keep clock under 17 MHz
					s_d.bits = s_q.bits + 5'd1;
					s_d.tmr  = 8'(HALF);
					s_d.st   = dsip_pkg::DSIP_HIGH;
				end
			end
			dsip_pkg::DSIP_HIGH: begin
				if (s_q.tmr == 8'h00) begin
					s_d.sclk = 1'b0;
					s_d.sr   = {s_q.sr[`DSIP_SHIFT_W-2:0], 1'b0};
					s_d.din  = s_q.sr[`DSIP_SHIFT_W-2];
					s_d.tmr  = 8'(HALF);
					// Whole frame in one select, extra fall included
					s_d.st   = (s_q.bits == 5'(`DSIP_FRAME_BITS)) ? dsip_pkg::DSIP_TAIL
					                                                 : dsip_pkg::DSIP_LOW;
				end
			end
			dsip_pkg::DSIP_TAIL: begin
				if (s_q.tmr == 8'h00) begin
					s_d.cs_n = 1'b1;   // Rises with clock low
					s_d.tmr  = 8'(GAP);
					s_d.st   = dsip_pkg::DSIP_GAP;
				end
			end
			dsip_pkg::DSIP_GAP: begin
				if (s_q.tmr == 8'h00)
					s_d.st = dsip_pkg::DSIP_IDLE;
			end
			default: s_d.st = dsip_pkg::DSIP_IDLE;
		endcase
		s_d.busy = (s_d.st != dsip_pkg::DSIP_IDLE);   // Registered busy flag
	end

	// State register
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_q      <= '0;
			s_q.st   <= dsip_pkg::DSIP_IDLE;
			s_q.cs_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.sclk = s_q.sclk;
	assign link.cs_n = s_q.cs_n;
	assign link.din  = s_q.din;
	assign o_busy    = s_q.busy;
endmodule : dsip_host
`default_nettype wire

/* bench/dsip_link_sva.sv */
// Purpose: Link and load checks between host and DAC port.
// Assumes: One 200 MHz domain for both ends.
// Notes:   Instantiated beside the link.
`timescale 1ns/1ps
`default_nettype none
module dsip_link_sva (
	input  wire logic                 i_clk,     // System clock
	input  wire logic                 i_resetn,  // Reset, active low
	input  wire logic                 sclk,      // Serial clock
	input  wire logic                 cs_n,      // Select, active low
	input  wire logic                 din,       // Data into device
	input  wire logic                 dout,      // Daisy out
	input  wire logic                 o_update,  // Load pulse
	input  wire dsip_pkg::dsip_code_t o_code     // Held code
);
	logic       sclk_q;
	logic [4:0] rise_cnt_q;
	// Count clock rises inside a frame
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sclk_q <= 1'b0;
			rise_cnt_q <= 5'h00;
		end else begin
			sclk_q <= sclk;
			rise_cnt_q <= cs_n ? 5'h00 : rise_cnt_q + 5'(sclk && !sclk_q);
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// Link timing and framing
	AST_CS_MOVE_CLK_LOW: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
		else $error("select moved with clock high");
	AST_IDLE_CLK_LOW: assert property (cs_n |-> !sclk)
		else $error("clock high while deselected");
	AST_SIXTEEN_RISES: assert property ($rose(cs_n) |-> rise_cnt_q == 5'h10)
		else $error("frame not sixteen clocks");
	AST_DIN_STEADY_HIGH: assert property (sclk |-> $stable(din))
		else $error("data moved while clock high");
	// Load of the held code
	AST_LOAD_AFTER_SELECT: assert property ($rose(cs_n) |-> ##[2:8] o_update)
		else $error("no load after select rise");
	AST_LOAD_PULSE: assert property (o_update |=> !o_update)
		else $error("load pulse too long");
	AST_CODE_ONLY_ON_LOAD: assert property ($changed(o_code) |-> o_update)
		else $error("code moved without load");
	// Daisy output
	AST_DOUT_ON_LOW_CLK: assert property ($changed(dout) |-> !sclk)
		else $error("daisy moved with clock high");
	AST_DOUT_HOLD: assert property (cs_n && $past(cs_n, 8) |-> $stable(dout))
		else $error("daisy moved while deselected");
	cover property ($rose(cs_n));
	cover property (o_update && o_code == 10'h3ff);
	cover property ($changed(dout));
endmodule : dsip_link_sva
`default_nettype wire

/* bench/dac_serial_input_port_bench.sv */
// Purpose: Host and DAC port joined back to back.
// Assumes: Host sends {4'h0, code, 2'b00} frames.
// Notes:   Queued expectations checked by monitors.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_input_port_bench;
	logic                 clk = 1'b0;
	logic                 resetn = 1'b0;
	logic                 valid = 1'b0;
	logic                 ready, busy, update, oe;
	dsip_pkg::dsip_code_t code_in = 10'h000;
	dsip_pkg::dsip_code_t code;
	dsip_pkg::dsip_code_t code_q[$];
	dsip_pkg::dsip_word_t frm_q[$];
	dsip_pkg::dsip_word_t fr, dw, prev_exp = 16'h0000;
	int                   n_fail = 0, cmp_count = 0, cycles = 0;
	logic                 saw_full = 1'b0;
	dsip_link_if link();
	dsip_host i_dsip_host (.i_clk(clk), .i_resetn(resetn), .i_valid(valid), .o_ready(ready),
		.i_code(code_in), .link(link.host), .o_busy(busy));
	dsip_device i_dsip_device (.i_clk(clk), .i_resetn(resetn), .link(link.device),
		.o_code(code), .o_update(update), .o_dout_oe(oe));
	dsip_link_sva i_dsip_link_sva (.i_clk(clk), .i_resetn(resetn), .sclk(link.sclk), .cs_n(link.cs_n),
		.din(link.din), .dout(link.dout), .o_update(update), .o_code(code));
	always #2.5 clk = ~clk;
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	// Offer one code, note its expected frame when taken
	task automatic send(input dsip_pkg::dsip_code_t c);
		code_in = c;
		valid = 1'b1;
		while (ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		code_q.push_back(c);
		frm_q.push_back({4'h0, c, 2'b00});
	endtask : send
	// Hang guard and full-buffer watch
	always @(posedge clk) begin
		cycles++;
		if (ready === 1'b0) saw_full = 1'b1;
		if (cycles == 20000) begin
			n_fail++;
			conclude();
		end
	end
	// Loaded code against oldest note
	always @(negedge clk) if (update === 1'b1) check("code", code, code_q.pop_front());
	// Capture wire bits at each clock rise
	always @(posedge link.sclk) begin
		fr = {fr[14:0], link.din};
		dw = {dw[14:0], link.dout};
	end
	// Frame on the wire and daisy copy of the frame before
	always @(posedge link.cs_n) if (resetn) begin
		dsip_pkg::dsip_word_t e;
		e = frm_q.pop_front();
		check("frame", fr, e);
		check("daisy", dw, prev_exp);
		prev_exp = e;
	end
	// Main sequence
	initial begin
		dsip_pkg::dsip_code_t tbl[4];
		int n;
		tbl = '{10'h000, 10'h3ff, 10'h200, 10'h1ff};
		void'($urandom(17));
		repeat (8) @(posedge clk);
		#1;
		resetn = 1'b1;
		@(posedge clk);
		#1;
		check("reset code", code, 16'h0000);
		check("dout enable", oe, 16'h0001);
		for (int i = 0; i < 12; i++) begin
			send(i < 4 ? tbl[i] : dsip_pkg::dsip_code_t'($urandom));
			n = (i < 6) ? 0 : $urandom % 3;
			if (n > 0) begin
				valid = 1'b0;
				repeat (n) @(posedge clk);
				#1;
			end
		end
		valid = 1'b0;
		while (code_q.size() > 0 || frm_q.size() > 0) @(posedge clk);
		repeat (20) @(posedge clk);
		check("buffer refused", saw_full, 16'h0001);
		check("idle busy", busy, 16'h0000);
		conclude();
	end
endmodule : dac_serial_input_port_bench
`default_nettype wire
